// ---- verilog/tcf_pkg.sv ----
/*
  Constants and types of the timed channel functions block.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
`default_nettype none

package tcf_pkg;

  localparam int NCH = 16;

  // Global register byte offsets.
  localparam logic [11:0] A_IRQ = 12'h000;
  localparam logic [11:0] A_PRESCALE = 12'h004;
  localparam logic [11:0] A_TB1 = 12'h008;
  localparam logic [11:0] A_TB2 = 12'h00C;
  localparam logic [11:0] A_FLAG = 12'h010;
  localparam logic [11:0] A_CH_BASE = 12'h200;

  // Word index inside one channel window of eight words.
  localparam logic [2:0] W_CTRL = 3'h0;
  localparam logic [2:0] W_PA = 3'h1;
  localparam logic [2:0] W_PB = 3'h2;
  localparam logic [2:0] W_PC = 3'h3;
  localparam logic [2:0] W_RES = 3'h4;
  localparam logic [2:0] W_STAT = 3'h5;

  // Field positions.
  localparam int CTRL_HSEQ_LSB = 4;
  localparam int CTRL_HSR_LSB = 6;
  localparam int CTRL_TBSEL_BIT = 8;
  localparam int PC_LCNT_LSB = 4;
  localparam int PC_FADDR_LSB = 8;
  localparam int PC_ACT_LSB = 12;
  localparam int PC_FEN_BIT = 15;
  localparam int HS_SINGLE_BIT = 0;
  localparam int HS_LINK_BIT = 1;
  localparam int HS_MODE_BIT = 0;

  // Reset and reload values, limits.
  localparam logic [7:0] PRESCALE_RST = 8'h01;
  localparam logic [15:0] TB2_RELOAD = 16'hFFFF;
  localparam logic [22:0] PER_MAX = 23'h7FFFFF;
  localparam logic [3:0] MAX_LINK = 4'h8;

  // Host sequence, service and pin action codes.
  localparam logic [1:0] HS_DIO_TRANS = 2'h0;
  localparam logic [1:0] HS_DIO_HOST = 2'h1;
  localparam logic [1:0] HS_DIO_RATE = 2'h2;
  localparam logic [1:0] HS_OC_IMM = 2'h0;
  localparam logic [1:0] HS_OC_REF = 2'h1;
  localparam logic [1:0] HSR_NONE = 2'h0;
  localparam logic [1:0] HSR_HIGH = 2'h1;
  localparam logic [1:0] HSR_SAMPLE = 2'h3;
  localparam logic [1:0] ACT_RISE = 2'h1;
  localparam logic [1:0] ACT_FALL = 2'h2;
  localparam logic [1:0] ACT_TOG = 2'h3;

  typedef enum logic [2:0] {
    FN_OFF, FN_DIO, FN_ITC, FN_OC, FN_PWM, FN_SYNCED_MODULATION_FUNCTION, FN_PMA, FN_PMM
  } tcf_func_e;

endpackage

`default_nettype wire

// ---- verilog/tcf_tb_if.sv ----
/*
  Carrier between the channel engine and the two time bases.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface tcf_tb_if;
  logic [7:0] prescale;
  logic pos_level;
  logic tb2_reload;
  logic tick;
  logic [15:0] tb1;
  logic [15:0] tb2;
  modport src (input prescale, pos_level, tb2_reload, output tick, tb1, tb2);
  modport user (output prescale, pos_level, tb2_reload, input tick, tb1, tb2);
endinterface

`default_nettype wire

// ---- verilog/tcf_time_bases.sv ----
/*
  The two time bases: one counts prescaled clock ticks, one counts rising
  edges of the position input. Assumes the position input is synchronous.
*/
`default_nettype none

module tcf_time_bases (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Time base carrier.
  tcf_tb_if.src tb
);

  logic [7:0] pre_cnt;
  logic pos_q;

  // Prescaler; a setting of 0 or 1 ticks on every clock.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt <= 8'h00;
      tb.tick <= 1'b0;
    end
    else
    begin
      tb.tick <= pre_cnt + 8'h01 >= tb.prescale;
      pre_cnt <= (pre_cnt + 8'h01 >= tb.prescale) ? 8'h00 : pre_cnt + 8'h01;
    end
  end

  // Internally clocked base.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tb.tb1 <= 16'h0000;
    else if (tb.tick)
      tb.tb1 <= tb.tb1 + 16'h0001; // RULE_21
  end

  // Position base; a reload from a tooth channel beats a count.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_q <= 1'b0;
      tb.tb2 <= 16'h0000;
    end
    else
    begin
      pos_q <= tb.pos_level;
      if (tb.tb2_reload)
        tb.tb2 <= tcf_pkg::TB2_RELOAD;
      else if (tb.pos_level && !pos_q)
        tb.tb2 <= tb.tb2 + 16'h0001; // RULE_21
    end
  end

endmodule

`default_nettype wire

// ---- verilog/tcf_time_processor.sv ----
/*
  Sixteen-channel timing engine with an APB register slave. Each channel
  runs one selectable time function on its own pin.
  Assumes APB3 signalling, pins synchronous to pclk, one clock domain.
*/
// The APB interface to the registers and the register addresses were chosen for this implementation.
// Operation
// RULE_01: sixteen channels, each with own pin hardware
// RULE_02: sixteen-level history, bit 15 newest
// RULE_03: history updates on transition, request or rate
// RULE_04: discrete output changes only on host request
// RULE_05: capture time base per transition count, interrupt
// RULE_06: continuous or single capture until reinit
// RULE_07: capture may link up to eight channels
// RULE_08: counted transition may increment shared flag byte
// RULE_09: compare action rise, fall or toggle
// RULE_10: immediate compare makes pulse of delay length
// RULE_11: referenced compare acts delay after given time
// RULE_12: linked compare makes square wave of period*ratio
// RULE_13: modulation with any duty from period, high time
// RULE_14: modulation update immediate or at next rise
// RULE_15: synced modulation aligns rising edges to link
// RULE_16: extra tooth when period below ratio of previous
// RULE_17: extra teeth counted, count reached reloads base
// RULE_18: flag byte nonzero reloads base on extra tooth
// RULE_19: missing tooth when period above ratio, counted
// RULE_20: flag byte nonzero reloads base on missing tooth
// RULE_21: internal base self clocked, position base by pin
// RULE_22: host service code cleared by device when done
// RULE_23: host sequence selects mode of the function
// RULE_24: interrupt pending until host clears it
`default_nettype none

module tcf_time_processor (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel pins.
  input wire logic [15:0] ch_in,
  output logic [15:0] ch_out,
  output logic [15:0] ch_oe,
  // Position indicator for the second time base.
  input wire logic position_in,
  // Per-channel pending interrupt requests.
  output logic [15:0] irq_pending
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tcf_pkg::tcf_func_e func [tcf_pkg::NCH];
  logic [1:0] hseq [tcf_pkg::NCH];
  logic [1:0] hsr [tcf_pkg::NCH];
  logic tbsel [tcf_pkg::NCH];
  logic [22:0] pa [tcf_pkg::NCH];
  logic [22:0] pb [tcf_pkg::NCH];
  logic [15:0] pc [tcf_pkg::NCH];
  logic [22:0] res [tcf_pkg::NCH];
  logic [22:0] prev [tcf_pkg::NCH];
  logic [22:0] cnt [tcf_pkg::NCH];
  logic [22:0] sh_pa [tcf_pkg::NCH];
  logic [22:0] sh_pb [tcf_pkg::NCH];
  logic [15:0] match [tcf_pkg::NCH];
  logic [15:0] link_q [tcf_pkg::NCH];
  logic [7:0] evc [tcf_pkg::NCH];
  logic [7:0] flag_mem [tcf_pkg::NCH];
  logic active [tcf_pkg::NCH];
  logic armed [tcf_pkg::NCH];
  logic pin_q [tcf_pkg::NCH];
  logic out_r [tcf_pkg::NCH];
  logic oe_r [tcf_pkg::NCH];
  logic irq_r [tcf_pkg::NCH];
  logic flag_q [tcf_pkg::NCH];
  logic t2_q [tcf_pkg::NCH];
  logic [7:0] prescale;
  logic [15:0] link_in;
  logic [15:0] flag_inc;
  logic [15:0] irq_vec;
  logic t2_any;
  logic [31:0] rdata;
  logic rerr;
  logic a_is_ch;
  logic [3:0] a_ch;
  logic [2:0] a_word;
  logic wr_en;
  logic fl_wr;

  tcf_tb_if tb_bus ();

  tcf_time_bases u_tb (
    .pclk(pclk),
    .presetn(presetn),
    .tb(tb_bus)
  );

  assign tb_bus.prescale = prescale;
  assign tb_bus.pos_level = position_in;
  assign tb_bus.tb2_reload = t2_any;

  // Pin action applied by an immediate request or by a referenced compare match.
  function automatic logic act_apply(input logic [1:0] act, input logic cur);
    logic v;
    v = cur;
    if (act == tcf_pkg::ACT_RISE)
      v = 1'b1;
    else if (act == tcf_pkg::ACT_FALL)
      v = 1'b0;
    else if (act == tcf_pkg::ACT_TOG)
      v = ~cur;
    return v;
  endfunction

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign a_is_ch = paddr[11:9] == tcf_pkg::A_CH_BASE[11:9];
  assign a_ch = paddr[8:5];
  assign a_word = paddr[4:2];
  assign wr_en = psel & penable & pready & pwrite;
  assign fl_wr = wr_en && paddr[11:4] == tcf_pkg::A_FLAG[11:4];

  // One wait state: data is sampled in the first access cycle, so a read
  // never sees a half-updated channel.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rerr;
      if (psel && penable && !pready && !pwrite)
        prdata <= rdata;
    end
  end

  // Read mux; unmapped words read zero with an error.
  always_comb
  begin
    rdata = 32'h00000000;
    rerr = 1'b0;
    if (a_is_ch)
    begin
      case (a_word)
        tcf_pkg::W_CTRL: rdata = {23'h0, tbsel[a_ch], hsr[a_ch], hseq[a_ch], 1'b0, func[a_ch]};
        tcf_pkg::W_PA: rdata = {9'h0, pa[a_ch]};
        tcf_pkg::W_PB: rdata = {9'h0, pb[a_ch]};
        tcf_pkg::W_PC: rdata = {16'h0, pc[a_ch]};
        tcf_pkg::W_RES: rdata = {9'h0, res[a_ch]};
        tcf_pkg::W_STAT: rdata = {16'h0, evc[a_ch], 3'h0, irq_r[a_ch], armed[a_ch],
          active[a_ch], oe_r[a_ch], out_r[a_ch]};
        default: rerr = 1'b1;
      endcase
    end
    else if (paddr == tcf_pkg::A_IRQ)
      rdata = {16'h0, irq_vec};
    else if (paddr == tcf_pkg::A_PRESCALE)
      rdata = {24'h0, prescale};
    else if (paddr == tcf_pkg::A_TB1)
      rdata = {16'h0, tb_bus.tb1};
    else if (paddr == tcf_pkg::A_TB2)
      rdata = {16'h0, tb_bus.tb2};
    else if (paddr[11:4] == tcf_pkg::A_FLAG[11:4])
      rdata = {flag_mem[{paddr[3:2], 2'h3}], flag_mem[{paddr[3:2], 2'h2}],
        flag_mem[{paddr[3:2], 2'h1}], flag_mem[{paddr[3:2], 2'h0}]};
    else
      rerr = 1'b1;
  end

  // Prescale register for the internal time base.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prescale <= tcf_pkg::PRESCALE_RST;
    else if (wr_en && paddr == tcf_pkg::A_PRESCALE)
      prescale <= pwdata[7:0];
  end

  // ****************************************************************
  // Cross-channel gathering
  // ****************************************************************
  // Links, flag increments and reloads from all channels are merged here.
  always_comb
  begin
    link_in = 16'h0000;
    flag_inc = 16'h0000;
    irq_vec = 16'h0000;
    ch_out = 16'h0000;
    ch_oe = 16'h0000;
    t2_any = 1'b0;
    for (int c = 0; c < tcf_pkg::NCH; c++)
    begin
      link_in = link_in | link_q[c]; // RULE_07
      if (flag_q[c])
        flag_inc[pc[c][tcf_pkg::PC_FADDR_LSB +: 4]] = 1'b1;
      t2_any = t2_any | t2_q[c];
      irq_vec[c] = irq_r[c];
      ch_out[c] = out_r[c];
      ch_oe[c] = oe_r[c];
    end
  end

  assign irq_pending = irq_vec;

  // ****************************************************************
  // Channels
  // ****************************************************************
  for (genvar i = 0; i < tcf_pkg::NCH; i++)
  begin : g_ch
    logic [15:0] tbv;
    logic [15:0] lmask;
    logic [15:0] offs;
    logic [23:0] oprod;
    logic [30:0] prod;
    logic [22:0] thr;
    logic [22:0] per;
    logic [22:0] hi;
    logic [3:0] lcnt;
    logic [1:0] act;
    logic edg;
    logic rise;
    logic hit;
    logic svc;
    logic wr_me;
    logic coh;
    logic tk;
    logic det;
    logic dio_upd;

    assign tk = tb_bus.tick;
    assign tbv = tbsel[i] ? tb_bus.tb2 : tb_bus.tb1;
    assign edg = ch_in[i] ^ pin_q[i];
    assign rise = ch_in[i] & ~pin_q[i];
    assign svc = hsr[i] != tcf_pkg::HSR_NONE;
    assign hit = armed[i] && tbv == match[i];
    assign wr_me = wr_en && a_is_ch && a_ch == 4'(i);
    assign act = pc[i][tcf_pkg::PC_ACT_LSB +: 2];
    assign oprod = pb[i][15:0] * pa[i][7:0];
    assign offs = oprod[23:8]; // RULE_12
    assign prod = prev[i] * pa[i][7:0];
    assign thr = prod[30:8];
    assign det = (func[i] == tcf_pkg::FN_PMA) ? cnt[i] < thr : cnt[i] > thr; // RULE_16 RULE_19
    assign coh = func[i] == tcf_pkg::FN_PWM && hseq[i][tcf_pkg::HS_MODE_BIT]; // RULE_14
    assign per = coh ? sh_pa[i] : pa[i];
    assign hi = coh ? sh_pb[i] : pb[i];
    assign dio_upd = (hseq[i] == tcf_pkg::HS_DIO_TRANS && edg)
      || (hseq[i] == tcf_pkg::HS_DIO_HOST && hsr[i] == tcf_pkg::HSR_SAMPLE)
      || (hseq[i] == tcf_pkg::HS_DIO_RATE && tk && cnt[i] + 23'h1 >= pa[i]); // RULE_03
    assign lcnt = pc[i][tcf_pkg::PC_LCNT_LSB +: 4] > tcf_pkg::MAX_LINK ?
      tcf_pkg::MAX_LINK : pc[i][tcf_pkg::PC_LCNT_LSB +: 4];

    // Block of consecutive channels to be linked, wrapping past 15.
    always_comb
    begin
      lmask = 16'h0000;
      for (int k = 0; k < 8; k++)
        if (4'(k) < lcnt)
          lmask[4'(pc[i][3:0] + 4'(k))] = 1'b1; // RULE_07
    end

    // Shared flag byte: an increment lands on top of a host write.
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        flag_mem[i] <= 8'h00;
      else
        flag_mem[i] <= ((fl_wr && paddr[3:2] == 2'(i / 4)) ? pwdata[8 * (i % 4) +: 8]
          : flag_mem[i]) + {7'h0, flag_inc[i]}; // RULE_08
    end

    // Channel engine; each channel has its own copy, so events on all
    // pins are handled in the same cycle.
    always_ff @(posedge pclk or negedge presetn) // RULE_01
    begin
      if (!presetn)
      begin
        func[i] <= tcf_pkg::FN_OFF;
        hseq[i] <= 2'h0;
        hsr[i] <= 2'h0;
        tbsel[i] <= 1'b0;
        pa[i] <= 23'h0;
        pb[i] <= 23'h0;
        pc[i] <= 16'h0000;
        res[i] <= 23'h0;
        prev[i] <= 23'h0;
        cnt[i] <= 23'h0;
        sh_pa[i] <= 23'h0;
        sh_pb[i] <= 23'h0;
        match[i] <= 16'h0000;
        link_q[i] <= 16'h0000;
        evc[i] <= 8'h00;
        active[i] <= 1'b0;
        armed[i] <= 1'b0;
        pin_q[i] <= 1'b0;
        out_r[i] <= 1'b0;
        oe_r[i] <= 1'b0;
        irq_r[i] <= 1'b0;
        flag_q[i] <= 1'b0;
        t2_q[i] <= 1'b0;
      end
      else
      begin
        pin_q[i] <= ch_in[i];
        link_q[i] <= 16'h0000;
        flag_q[i] <= 1'b0;
        t2_q[i] <= 1'b0;
        if (svc)
          hsr[i] <= tcf_pkg::HSR_NONE; // RULE_22
        if (wr_en && paddr == tcf_pkg::A_IRQ && pwdata[i])
          irq_r[i] <= 1'b0; // RULE_24
        unique case (func[i]) // RULE_23
          tcf_pkg::FN_OFF:
          begin
            oe_r[i] <= 1'b0;
            active[i] <= 1'b0;
            armed[i] <= 1'b0;
          end
          tcf_pkg::FN_DIO:
          begin
            if (svc && hsr[i] != tcf_pkg::HSR_SAMPLE)
            begin
              out_r[i] <= hsr[i] == tcf_pkg::HSR_HIGH; // RULE_04
              oe_r[i] <= 1'b1;
            end
            if (hsr[i] == tcf_pkg::HSR_SAMPLE)
              oe_r[i] <= 1'b0;
            if (tk && hseq[i] == tcf_pkg::HS_DIO_RATE)
              cnt[i] <= (cnt[i] + 23'h1 >= pa[i]) ? 23'h0 : cnt[i] + 23'h1;
            if (dio_upd)
            begin
              res[i] <= {7'h0, ch_in[i], res[i][15:1]}; // RULE_02
              irq_r[i] <= 1'b1;
            end
          end
          tcf_pkg::FN_ITC:
          begin
            if (svc)
            begin
              active[i] <= 1'b1;
              evc[i] <= 8'h00;
              oe_r[i] <= 1'b0;
            end
            else if (active[i] && edg)
            begin
              flag_q[i] <= pc[i][tcf_pkg::PC_FEN_BIT]; // RULE_08
              if (evc[i] + 8'h01 >= pa[i][7:0])
              begin
                res[i] <= {7'h0, tbv}; // RULE_05
                irq_r[i] <= 1'b1;
                evc[i] <= 8'h00;
                if (hseq[i][tcf_pkg::HS_SINGLE_BIT])
                  active[i] <= 1'b0; // RULE_06
                if (hseq[i][tcf_pkg::HS_LINK_BIT])
                  link_q[i] <= lmask; // RULE_07
              end
              else
                evc[i] <= evc[i] + 8'h01;
            end
          end
          tcf_pkg::FN_OC:
          begin
            if (svc)
            begin
              oe_r[i] <= 1'b1;
              armed[i] <= hseq[i] == tcf_pkg::HS_OC_IMM || hseq[i] == tcf_pkg::HS_OC_REF;
              if (hseq[i] == tcf_pkg::HS_OC_IMM)
              begin
                out_r[i] <= act_apply(act, out_r[i]); // RULE_09 RULE_10
                match[i] <= tbv + pa[i][15:0];
              end
              else
                match[i] <= pb[i][15:0] + pa[i][15:0]; // RULE_11
            end
            else if (link_in[i] && hseq[i] > tcf_pkg::HS_OC_REF)
            begin
              match[i] <= tbv + offs; // RULE_12
              armed[i] <= 1'b1;
              res[i] <= {7'h0, offs};
            end
            else if (hit)
            begin
              irq_r[i] <= 1'b1;
              if (hseq[i] == tcf_pkg::HS_OC_REF)
                out_r[i] <= act_apply(act, out_r[i]); // RULE_09
              else
                out_r[i] <= ~out_r[i]; // RULE_10 RULE_12
              if (hseq[i] > tcf_pkg::HS_OC_REF)
                match[i] <= match[i] + offs;
              else
                armed[i] <= 1'b0;
            end
          end
          tcf_pkg::FN_PWM, tcf_pkg::FN_SYNCED_MODULATION_FUNCTION:
          begin
            if (svc)
            begin
              active[i] <= 1'b1;
              oe_r[i] <= 1'b1;
              cnt[i] <= 23'h0;
              sh_pa[i] <= pa[i];
              sh_pb[i] <= pb[i];
              out_r[i] <= pb[i] != 23'h0;
            end
            else if (func[i] == tcf_pkg::FN_SYNCED_MODULATION_FUNCTION && link_in[i])
            begin
              cnt[i] <= 23'h0; // RULE_15
              out_r[i] <= pb[i] != 23'h0;
            end
            else if (active[i] && tk)
            begin
              if (cnt[i] + 23'h1 >= per)
              begin
                cnt[i] <= 23'h0;
                sh_pa[i] <= pa[i]; // RULE_14
                sh_pb[i] <= pb[i];
                out_r[i] <= pb[i] != 23'h0; // RULE_13
              end
              else
              begin
                cnt[i] <= cnt[i] + 23'h1;
                if (cnt[i] + 23'h1 == hi)
                  out_r[i] <= 1'b0; // RULE_13
              end
            end
          end
          tcf_pkg::FN_PMA, tcf_pkg::FN_PMM:
          begin
            if (svc)
            begin
              active[i] <= 1'b1;
              oe_r[i] <= 1'b0;
              cnt[i] <= 23'h0;
              evc[i] <= 8'h00;
              prev[i] <= 23'h0;
            end
            else if (active[i] && rise)
            begin
              res[i] <= cnt[i]; // RULE_16 RULE_19
              prev[i] <= cnt[i];
              cnt[i] <= 23'h0;
              if (prev[i] != 23'h0 && det)
              begin
                irq_r[i] <= 1'b1;
                if (hseq[i][tcf_pkg::HS_MODE_BIT])
                  t2_q[i] <= flag_mem[pc[i][tcf_pkg::PC_FADDR_LSB +: 4]] != 8'h00; // RULE_18 RULE_20
                else if (evc[i] + 8'h01 >= pb[i][7:0])
                begin
                  t2_q[i] <= 1'b1; // RULE_17 RULE_19
                  evc[i] <= 8'h00;
                end
                else
                  evc[i] <= evc[i] + 8'h01;
              end
            end
            else if (active[i] && tk && cnt[i] != tcf_pkg::PER_MAX)
              cnt[i] <= cnt[i] + 23'h1;
          end
        endcase
        // Host writes come last, so a new service request beats the clear.
        if (wr_me)
        begin
          case (a_word)
            tcf_pkg::W_CTRL:
            begin
              func[i] <= tcf_pkg::tcf_func_e'(pwdata[2:0]);
              hseq[i] <= pwdata[tcf_pkg::CTRL_HSEQ_LSB +: 2];
              tbsel[i] <= pwdata[tcf_pkg::CTRL_TBSEL_BIT];
              if (pwdata[tcf_pkg::CTRL_HSR_LSB +: 2] != tcf_pkg::HSR_NONE)
                hsr[i] <= pwdata[tcf_pkg::CTRL_HSR_LSB +: 2]; // RULE_22
            end
            tcf_pkg::W_PA: pa[i] <= pwdata[22:0];
            tcf_pkg::W_PB: pb[i] <= pwdata[22:0];
            tcf_pkg::W_PC: pc[i] <= pwdata[15:0];
            default: ;
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- verif/tcf_pin_model.sv ----
/*
  Sensors and loads on the sixteen channel pins.
  Assumes the testbench sets each sensor level between clock edges.
*/
`default_nettype none

module tcf_pin_model (
  // Pins as the block drives them.
  input wire logic [15:0] ch_out,
  input wire logic [15:0] ch_oe,
  // Level each sensor presents while its pin is released.
  input wire logic [15:0] sensor,
  // Level the block sees.
  output logic [15:0] ch_in
);
  // A driven pin reads back its own level.
  assign ch_in = (ch_oe & ch_out) | (~ch_oe & sensor);
endmodule

`default_nettype wire

// ---- verif/tcf_time_processor_checker.sv ----
/*
  Port assertions for the timing engine.
  Assumes it is bound to tcf_time_processor, one clock domain.
*/
`default_nettype none

module tcf_time_processor_checker (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and requests.
  input wire logic [15:0] ch_in,
  input wire logic [15:0] ch_out,
  input wire logic [15:0] ch_oe,
  input wire logic position_in,
  input wire logic [15:0] irq_pending
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_done;
  logic [15:0] clr;
  logic [3:0] since_wr;

  // Bits a completed write to the pending register clears.
  assign wr_done = psel && penable && pready && pwrite;
  assign clr = (wr_done && paddr == tcf_pkg::A_IRQ) ? pwdata[15:0] : 16'h0000;

  // Cycles since the last write, saturating.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      since_wr <= 4'hF;
    else if (wr_done)
      since_wr <= 4'h0;
    else if (since_wr != 4'hF)
      since_wr <= since_wr + 4'h1;

  // ********************
  // Assertions
  // ********************
  a_ready_one_late: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_err_unmapped: assert property (pready && paddr >= tcf_pkg::A_CH_BASE
    && paddr[4:3] == 2'b11 |-> pslverr) else $error("unmapped accepted");
  a_err_mapped: assert property (pready && paddr == tcf_pkg::A_IRQ |-> !pslverr)
    else $error("mapped refused");
  a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved");
  a_irq_held: assert property ((($past(irq_pending) & ~irq_pending) & ~$past(clr)) == 16'h0000)
    else $error("request dropped");
  a_drive_on_request: assert property (|(ch_oe & ~$past(ch_oe)) |-> since_wr <= 4'h4)
    else $error("pin driven unasked");
endmodule

`default_nettype wire

// ---- verif/timed_channel_functions_tb.sv ----
/*
  Self-checking bench for the timing engine.
  Assumes pins reach sensors through tcf_pin_model.
*/
`default_nettype none

module timed_channel_functions_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic position_in = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  logic [15:0] ch_in, ch_out, ch_oe, irq_pending;
  logic [15:0] sensor = 16'h0000;
  logic [31:0] seed = 32'hC78A1637;
  int fail_count = 0;
  int n_compared = 0;
  int c, n, pa, k;

  // Free-running 125 MHz clock.
  always #4 pclk = ~pclk;

  tcf_time_processor u_dut (.*);
  tcf_pin_model u_pins (.*);

  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Byte address of word w in the window of channel ch.
  function automatic logic [11:0] ca(input int ch, input logic [2:0] w);
    return tcf_pkg::A_CH_BASE + 12'(ch * 32) + 12'({w, 2'b00});
  endfunction

  // Pin level after a compare action.
  function automatic logic act_level(input logic [1:0] act, input logic prev);
    return act == tcf_pkg::ACT_RISE ? 1'b1 : (act == tcf_pkg::ACT_FALL ? 1'b0 : ~prev);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int m);
    repeat (m) @(posedge pclk);
  endtask

  // One APB transfer; ends with an idle cycle.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    chk({31'h0, pready}, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Service request, then read back its clear.
  task automatic svc(input int ch, input logic [31:0] ctrl);
    apb(1'b1, ca(ch, tcf_pkg::W_CTRL), ctrl);
    apb(1'b0, ca(ch, tcf_pkg::W_CTRL), 32'h0);
    chk({30'h0, q[7:6]}, {30'h0, tcf_pkg::HSR_NONE});
  endtask

  task automatic edge_in(input int ch);
    sensor[ch] <= ~sensor[ch];
    cyc(4);
  endtask

  task tally_and_finish;
    $display("Mismatches %0d, comparisons %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial
  begin
    cyc(20000);
    fail_count++;
    tally_and_finish;
  end

  // ********************
  // Scenarios
  // ********************
  initial
  begin
    cyc(6);
    presetn <= 1'b1;
    cyc(1);
    // Reset values, then a reserved word that must be refused.
    apb(1'b0, tcf_pkg::A_PRESCALE, 32'h0);
    chk(q, {24'h0, tcf_pkg::PRESCALE_RST});
    apb(1'b1, ca(3, 3'h6), 32'hFFFF_FFFF);
    apb(1'b0, ca(3, 3'h6), 32'h0);
    chk({q[30:0], e}, 32'h1);
    // The position base counts rising edges of the position input.
    n = 1 + rnd() % 8;
    repeat (n)
    begin
      position_in <= 1'b1;
      cyc(2);
      position_in <= 1'b0;
      cyc(2);
    end
    apb(1'b0, tcf_pkg::A_TB2, 32'h0);
    chk(q, 32'(n));
    // Discrete pin: drive high, low, then release and sample three times.
    c = rnd() % 16;
    sensor[c] <= 1'b1;
    svc(c, 32'h51);
    chk({30'h0, ch_oe[c], ch_out[c]}, 32'h3);
    svc(c, 32'h91);
    chk({30'h0, ch_oe[c], ch_out[c]}, 32'h2);
    svc(c, 32'hD1);
    svc(c, 32'hD1);
    sensor[c] <= 1'b0;
    cyc(2);
    svc(c, 32'hD1);
    apb(1'b0, ca(c, tcf_pkg::W_RES), 32'h0);
    chk({30'h0, q[15:14]}, 32'h1);
    chk({31'h0, irq_pending[c]}, 32'h1);
    apb(1'b1, tcf_pkg::A_IRQ, 32'h1 << c);
    chk({31'h0, irq_pending[c]}, 32'h0);
    // Immediate compare per action; pulse lasts the delay.
    for (int i = 1; i < 4; i++)
    begin
      k = (c + i) % 16;
      pa = 10 + rnd() % 20;
      apb(1'b1, ca(k, tcf_pkg::W_PA), 32'(pa));
      apb(1'b1, ca(k, tcf_pkg::W_PC), 32'(i) << tcf_pkg::PC_ACT_LSB);
      apb(1'b1, ca(k, tcf_pkg::W_CTRL), 32'h43);
      cyc(2);
      chk({31'h0, ch_out[k]}, {31'h0, act_level(2'(i), 1'b0)});
      n = 0;
      while (ch_out[k] === act_level(2'(i), 1'b0) && n < 300)
      begin
        cyc(1);
        n++;
      end
      chk({31'h0, n >= pa - 4 && n <= pa + 1}, 32'h1);
    end
    // Single capture: request on counted edge only.
    k = (c + 5) % 16;
    n = 2 + rnd() % 4;
    apb(1'b1, ca(k, tcf_pkg::W_PA), 32'(n));
    svc(k, 32'h52);
    repeat (n - 1) edge_in(k);
    chk({31'h0, irq_pending[k]}, 32'h0);
    edge_in(k);
    chk({31'h0, irq_pending[k]}, 32'h1);
    apb(1'b1, tcf_pkg::A_IRQ, 32'h1 << k);
    repeat (n) edge_in(k);
    chk({31'h0, irq_pending[k]}, 32'h0);
    tally_and_finish;
  end
endmodule

bind tcf_time_processor tcf_time_processor_checker u_chk (.*);

`default_nettype wire
